// *** include/phi_pkg.sv ***
package phi_pkg;

  // Register byte offsets on the APB slave.
  localparam logic [11:0] PHI_OFF_CTRL = 12'h000;
  localparam logic [11:0] PHI_OFF_EVENT = 12'h004;
  localparam logic [11:0] PHI_OFF_STATUS = 12'h008;
  localparam logic [11:0] PHI_OFF_MSGCNT = 12'h00C;

  // Control register fields.
  localparam int PHI_CTRL_PWR_LSB = 0;
  localparam int PHI_CTRL_PME_BIT = 2;
  localparam int PHI_CTRL_MSI_BIT = 3;
  localparam int PHI_CTRL_MSIX_BIT = 4;
  localparam int PHI_CTRL_INTXDIS_BIT = 5;
  localparam int PHI_CTRL_MMEN_LSB = 6;
  localparam logic [8:0] PHI_CTRL_RESET = 9'h000;

  // Event register strobes, write-only.
  localparam int PHI_EVT_TURNOFF_BIT = 0;
  localparam int PHI_EVT_LINKUP_BIT = 1;
  localparam int PHI_EVT_LINKDOWN_BIT = 2;

  // Status register fields.
  localparam int PHI_STS_LINK_LSB = 0;
  localparam int PHI_STS_TO_LSB = 2;
  localparam int PHI_STS_WAKE_BIT = 4;
  localparam int PHI_STS_ACK_BIT = 5;
  localparam int PHI_STS_BLK_BIT = 6;
  localparam int PHI_STS_UNSUP_BIT = 7;
  localparam int PHI_STS_INTA_BIT = 8;
  localparam int PHI_STS_PKT_BIT = 9;
  localparam logic [3:0] PHI_STICKY_RESET = 4'h0;
  localparam logic [15:0] PHI_CNT_RESET = 16'h0000;

  localparam logic [7:0] PHI_INTA_VECTOR = 8'h00;
  localparam logic [2:0] PHI_MM_CAP_DEFAULT = 3'h5;

  typedef enum logic [1:0] {
    PHI_PWR_D0 = 2'b00,
    PHI_PWR_D1 = 2'b01,
    PHI_PWR_D2 = 2'b10,
    PHI_PWR_D3HOT = 2'b11
  } phi_pwr_t;

  typedef enum logic [1:0] {
    PHI_LINK_DOWN = 2'b00,
    PHI_LINK_L0 = 2'b01,
    PHI_LINK_L1 = 2'b11,
    PHI_LINK_L3 = 2'b10
  } phi_link_t;

  typedef enum logic [1:0] {
    PHI_TO_IDLE = 2'b00,
    PHI_TO_REQ = 2'b01,
    PHI_TO_ACK = 2'b11,
    PHI_TO_OFF = 2'b10
  } phi_to_t;

endpackage : phi_pkg

// *** include/phi_irq_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface phi_irq_if;
  logic enable;
  logic closed;
  logic msi_en;
  logic msix_en;
  logic intx_dis;
  logic [2:0] mmen;
  logic rdy;
  logic intx_send;
  logic intx_assert;
  logic msi_send;
  logic [7:0] msi_data;
  logic blocked;
  logic unsup;

  modport ctl (
    output enable, closed, msi_en, msix_en, intx_dis, mmen,
    input rdy, intx_send, intx_assert, msi_send, msi_data, blocked, unsup
  );
  modport irq (
    input enable, closed, msi_en, msix_en, intx_dis, mmen,
    output rdy, intx_send, intx_assert, msi_send, msi_data, blocked, unsup
  );
endinterface : phi_irq_if
`default_nettype wire

// *** logic/phi_irq_ctrl.sv ***
`timescale 1ns/1ps
`default_nettype none
module phi_irq_ctrl
  import phi_pkg::*;
#(
  parameter logic [2:0] MM_CAPABLE = PHI_MM_CAP_DEFAULT
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic intr_req_low,
  input wire logic intr_assert_low,
  input wire logic [7:0] intr_di,
  phi_irq_if.irq bus
);

  logic rdy_r;
  logic intx_send_r;
  logic intx_assert_r;
  logic msi_send_r;
  logic [7:0] msi_data_r;
  logic blocked_r;
  logic unsup_r;

  // A request held low after its accept is a new interrupt, so accept never fires twice in a row.
  wire take = bus.enable && !bus.closed && !intr_req_low && !rdy_r; // RL20 RL21 RL14
  wire legacy = !bus.msi_en; // RL16 RL17
  wire intx_ok = legacy && !bus.intx_dis && (intr_di == PHI_INTA_VECTOR); // RL19
  wire [2:0] mm_lim = (bus.mmen < MM_CAPABLE) ? bus.mmen : MM_CAPABLE;
  wire [8:0] mm_one = 9'h001 << mm_lim;
  wire [7:0] mm_mask = mm_one[7:0] - 8'h01;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rdy_r <= 1'b0;
      intx_send_r <= 1'b0;
      intx_assert_r <= 1'b0;
      msi_send_r <= 1'b0;
      msi_data_r <= 8'h00;
      blocked_r <= 1'b0;
      unsup_r <= 1'b0;
    end else begin
      rdy_r <= take; // RL20 RL22
      intx_send_r <= take && intx_ok; // RL16
      intx_assert_r <= (take && intx_ok) ? !intr_assert_low : intx_assert_r;
      msi_send_r <= take && bus.msi_en; // RL16 RL18
      msi_data_r <= take ? (intr_di & mm_mask) : msi_data_r;
      blocked_r <= take && legacy && bus.intx_dis; // RL19
      unsup_r <= take && legacy && !bus.intx_dis && (intr_di != PHI_INTA_VECTOR);
    end
  end

  assign bus.rdy = rdy_r;
  assign bus.intx_send = intx_send_r;
  assign bus.intx_assert = intx_assert_r;
  assign bus.msi_send = msi_send_r;
  assign bus.msi_data = msi_data_r;
  assign bus.blocked = blocked_r;
  assign bus.unsup = unsup_r;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  AST_IRQ_ACCEPT: assert property (take |=> bus.rdy ##1 !bus.rdy) // RL20
    else $error("interrupt request not accepted for exactly one cycle");
  AST_IRQ_MODE: assert property (bus.intx_send |-> $past(!bus.msi_en)) // RL16
    else $error("INTx sent while MSI enabled");
  AST_IRQ_INTXDIS: assert property (bus.intx_send |-> $past(!bus.intx_dis)) // RL19
    else $error("INTx sent while interrupt disable set");
  AST_IRQ_ONE_KIND: assert property (!(bus.intx_send && bus.msi_send)) // RL18
    else $error("two interrupt kinds sent at once");
  AST_IRQ_ROOTPORT: assert property (!bus.enable |-> !bus.rdy) // RL14
    else $error("interrupt accepted in root port build");
  AST_IRQ_SEND_CAUSE: assert property ((bus.intx_send || bus.msi_send) |-> bus.rdy) // RL17
    else $error("interrupt message without accept");

endmodule : phi_irq_ctrl
`default_nettype wire

// *** logic/phi_pm_irq.sv ***
// Functional notes
// RL1 - L0s entry and exit happen inside the link layer, invisible to user logic.
// RL2 - Link states L0, L1 and L3 are supported, moved by the upstream side.
// RL3 - L0 is entered only after link training completes.
// RL4 - The programmed function power state is shown on a two-bit output.
// RL5 - Outside D0 transmit ready drops, but a packet already started finishes.
// RL6 - Endpoint user logic sends no new requests outside D0, completions allowed.
// RL7 - Root port user logic should send no new requests outside D0.
// RL8 - The link enters L1 by packet exchange without user involvement.
// RL9 - Wake requests outside D0 are honoured only when PME enable is set.
// RL10 - A turn-off message raises the turn-off request and starts polling acknowledge.
// RL11 - The turn-off request stays asserted until user acknowledge arrives.
// RL12 - User logic finishes its packet, then acknowledges turn-off irrevocably.
// RL13 - After the handshake an acknowledge message goes out and all layers close.
// RL14 - Interrupt requests exist only in an endpoint build.
// RL15 - MSI and MSI-X enable are mirrored out; only the upstream side writes them.
// RL16 - Both enables clear sends INTx only; MSI enable alone sends MSI only.
// RL17 - With MSI-X enable, the request port still sends INTx or MSI.
// RL18 - The interrupt controller never produces MSI-X messages.
// RL19 - Legacy interrupts are blocked while the interrupt disable bit is set.
// RL20 - An active-low request is held until the active-low ready accepts it.
// RL21 - User logic releases the request the cycle after accept unless another follows.
// RL22 - Handshake signals are active low and synchronous to the clock.
`timescale 1ns/1ps
`default_nettype none
module phi_pm_irq
  import phi_pkg::*;
#(
  parameter bit IS_ENDPOINT = 1'b1,
  parameter logic [2:0] MM_CAPABLE = PHI_MM_CAP_DEFAULT
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [1:0] power_state,
  output logic pme_enable,
  output logic [1:0] link_state,
  input wire logic tx_src_rdy_low,
  input wire logic tx_sof_low,
  input wire logic tx_eof_low,
  output logic tx_dst_rdy_low,
  input wire logic wake_request_low,
  output logic pme_msg_send,
  output logic turnoff_request_low,
  input wire logic turnoff_ok_low,
  output logic turnoff_ack_send,
  output logic layers_disabled,
  input wire logic intr_req_low,
  input wire logic intr_assert_low,
  input wire logic [7:0] intr_di,
  output logic intr_rdy_low,
  output logic msi_enable,
  output logic msix_enable,
  output logic [2:0] mmenable,
  output logic intx_msg_send,
  output logic intx_msg_assert,
  output logic msi_msg_send,
  output logic [7:0] msi_msg_data
);

  // APB decode.
  wire setup = psel && !penable;
  wire access = psel && penable;
  wire hit_ctrl = (paddr == PHI_OFF_CTRL);
  wire hit_event = (paddr == PHI_OFF_EVENT);
  wire hit_status = (paddr == PHI_OFF_STATUS);
  wire hit_cnt = (paddr == PHI_OFF_MSGCNT);
  wire hit_any = hit_ctrl || hit_event || hit_status || hit_cnt;
  wire wr = access && pwrite && hit_any;
  wire wr_ctrl = wr && hit_ctrl;
  wire wr_event = wr && hit_event;
  wire wr_status = wr && hit_status;

  // The control register stands for the configuration space that only the upstream side writes.
  logic [8:0] ctrl_r;
  logic [8:0] ctrl_nxt;
  wire [1:0] pwr = ctrl_r[PHI_CTRL_PWR_LSB +: 2];
  wire non_d0 = (pwr != PHI_PWR_D0);

  always_comb begin
    ctrl_nxt = ctrl_r;
    if (wr_ctrl) begin
      ctrl_nxt = pwdata[8:0]; // RL15
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ctrl_r <= PHI_CTRL_RESET;
    end else begin
      ctrl_r <= ctrl_nxt;
    end
  end

  assign power_state = pwr; // RL4
  assign pme_enable = ctrl_r[PHI_CTRL_PME_BIT];
  assign msi_enable = ctrl_r[PHI_CTRL_MSI_BIT]; // RL15
  assign msix_enable = ctrl_r[PHI_CTRL_MSIX_BIT]; // RL15
  assign mmenable = ctrl_r[PHI_CTRL_MMEN_LSB +: 3];

  wire evt_turnoff = wr_event && pwdata[PHI_EVT_TURNOFF_BIT];
  wire evt_linkup = wr_event && pwdata[PHI_EVT_LINKUP_BIT];
  wire evt_linkdown = wr_event && pwdata[PHI_EVT_LINKDOWN_BIT];

  // Turn-off handshake.
  phi_to_t to_r;
  phi_to_t to_nxt;

  always_comb begin
    to_nxt = to_r;
    case (to_r)
      PHI_TO_IDLE: begin
        if (evt_turnoff) begin
          to_nxt = PHI_TO_REQ; // RL10
        end
      end
      PHI_TO_REQ: begin
        // User logic has drained its packets before it acknowledges.
        if (!turnoff_ok_low) begin
          to_nxt = PHI_TO_ACK; // RL11 RL12
        end
      end
      PHI_TO_ACK: to_nxt = PHI_TO_OFF; // RL13
      PHI_TO_OFF: to_nxt = PHI_TO_OFF;
      default: to_nxt = PHI_TO_IDLE;
    endcase
  end

  logic to_req_low_r;
  logic ack_send_r;
  logic off_r;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      to_r <= PHI_TO_IDLE;
      to_req_low_r <= 1'b1;
      ack_send_r <= 1'b0;
      off_r <= 1'b0;
    end else begin
      to_r <= to_nxt;
      to_req_low_r <= (to_nxt != PHI_TO_REQ); // RL11 RL22
      ack_send_r <= (to_nxt == PHI_TO_ACK); // RL13
      off_r <= (to_nxt == PHI_TO_OFF); // RL13
    end
  end

  assign turnoff_request_low = to_req_low_r;
  assign turnoff_ack_send = ack_send_r;
  assign layers_disabled = off_r;

  // Programmed link state; L0s is handled below this block and never shows here.
  phi_link_t link_r;
  phi_link_t link_nxt;

  always_comb begin
    link_nxt = link_r;
    case (link_r)
      PHI_LINK_DOWN: begin
        if (evt_linkup) begin
          link_nxt = PHI_LINK_L0; // RL3 RL1
        end
      end
      PHI_LINK_L0: begin
        if (non_d0) begin
          link_nxt = PHI_LINK_L1; // RL2 RL8
        end
      end
      PHI_LINK_L1: begin
        if (!non_d0) begin
          link_nxt = PHI_LINK_L0; // RL2
        end
      end
      PHI_LINK_L3: link_nxt = PHI_LINK_L3;
      default: link_nxt = PHI_LINK_DOWN;
    endcase
    if (evt_linkdown && link_r != PHI_LINK_L3) begin
      link_nxt = PHI_LINK_DOWN;
    end
    if (to_nxt == PHI_TO_OFF) begin
      link_nxt = PHI_LINK_L3; // RL2 RL13
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      link_r <= PHI_LINK_DOWN;
    end else begin
      link_r <= link_nxt;
    end
  end

  assign link_state = link_r;

  // Transmit throttle: a packet already under way outside D0 is still taken to its end.
  logic in_pkt_r;
  wire tx_open = (!non_d0 || in_pkt_r) && !off_r; // RL5 RL13
  wire beat = !tx_src_rdy_low && tx_open;
  // A beat with no start while no packet is open is a stray and must not open a packet that keeps transmit ready outside D0.
  wire in_pkt_nxt = beat ? ((in_pkt_r || !tx_sof_low) && tx_eof_low) : in_pkt_r;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      in_pkt_r <= 1'b0;
    end else begin
      in_pkt_r <= in_pkt_nxt; // RL5
    end
  end

  assign tx_dst_rdy_low = !tx_open; // RL5 RL22

  // Wake: at most one PME message per falling edge of the request.
  logic wake_prev_r;
  logic pme_send_r;
  wire wake_edge = !wake_request_low && wake_prev_r;
  wire pme_go = wake_edge && non_d0 && pme_enable && !off_r; // RL9

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      wake_prev_r <= 1'b1;
      pme_send_r <= 1'b0;
    end else begin
      wake_prev_r <= wake_request_low;
      pme_send_r <= pme_go; // RL9
    end
  end

  assign pme_msg_send = pme_send_r;

  // Interrupt request controller.
  phi_irq_if irq_bus ();

  assign irq_bus.enable = IS_ENDPOINT; // RL14
  assign irq_bus.closed = off_r;
  assign irq_bus.msi_en = msi_enable;
  assign irq_bus.msix_en = msix_enable; // RL17
  assign irq_bus.intx_dis = ctrl_r[PHI_CTRL_INTXDIS_BIT]; // RL19
  assign irq_bus.mmen = mmenable;

  phi_irq_ctrl #(
    .MM_CAPABLE(MM_CAPABLE)
  ) u_irq (
    .clk(clk),
    .reset_n(reset_n),
    .intr_req_low(intr_req_low),
    .intr_assert_low(intr_assert_low),
    .intr_di(intr_di),
    .bus(irq_bus)
  );

  assign intr_rdy_low = !irq_bus.rdy; // RL20 RL22
  assign intx_msg_send = irq_bus.intx_send;
  assign intx_msg_assert = irq_bus.intx_assert;
  assign msi_msg_send = irq_bus.msi_send; // RL18
  assign msi_msg_data = irq_bus.msi_data;

  // Sticky status, cleared by writing one; a new event in the clearing cycle wins.
  logic [3:0] sticky_r;
  wire [3:0] sticky_set = {irq_bus.unsup, irq_bus.blocked, ack_send_r, pme_send_r};
  wire [3:0] sticky_clr = wr_status ? pwdata[PHI_STS_UNSUP_BIT:PHI_STS_WAKE_BIT] : 4'h0;

  logic [15:0] irq_cnt_r;
  logic [15:0] pm_cnt_r;
  wire irq_sent = irq_bus.intx_send || irq_bus.msi_send;
  wire [15:0] pm_inc = {15'h0000, pme_send_r} + {15'h0000, ack_send_r};

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      sticky_r <= PHI_STICKY_RESET;
      irq_cnt_r <= PHI_CNT_RESET;
      pm_cnt_r <= PHI_CNT_RESET;
    end else begin
      sticky_r <= (sticky_r & ~sticky_clr) | sticky_set;
      irq_cnt_r <= irq_cnt_r + {15'h0000, irq_sent};
      pm_cnt_r <= pm_cnt_r + pm_inc;
    end
  end

  wire [31:0] status_word = {22'h000000, in_pkt_r, irq_bus.intx_assert, sticky_r, to_r, link_r};
  wire [31:0] read_word = hit_ctrl ? {23'h000000, ctrl_r} :
                          hit_status ? status_word :
                          hit_cnt ? {pm_cnt_r, irq_cnt_r} : 32'h0000_0000;

  // Read data is captured in the setup cycle, so the slave answers with no wait state.
  logic [31:0] prdata_r;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      prdata_r <= 32'h0000_0000;
    end else if (setup) begin
      prdata_r <= pwrite ? 32'h0000_0000 : read_word;
    end
  end

  assign prdata = prdata_r;
  assign pready = 1'b1;
  assign pslverr = access && !hit_any;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  AST_PWR_SHOWN: assert property (wr_ctrl |=> power_state == $past(pwdata[1:0])) // RL4
    else $error("power state output not updated from write");
  AST_TX_STALL: assert property ((non_d0 && !in_pkt_r) |-> tx_dst_rdy_low) // RL5
    else $error("transmit ready outside D0 with no packet open");
  AST_TX_FINISH: assert property ((in_pkt_r && !off_r) |-> !tx_dst_rdy_low) // RL5
    else $error("open packet stalled");
  AST_WAKE_GATE: assert property (pme_msg_send |-> $past(pme_enable) && $past(non_d0)) // RL9
    else $error("wake honoured without PME enable");
  AST_TO_RAISE: assert property ((evt_turnoff && to_r == PHI_TO_IDLE) |=> !turnoff_request_low) // RL10
    else $error("turn-off request not raised");
  AST_TO_HOLD: assert property ((!turnoff_request_low && turnoff_ok_low) |=> !turnoff_request_low) // RL11
    else $error("turn-off request dropped before acknowledge");
  AST_TO_CLOSE: assert property (turnoff_ack_send |=> layers_disabled && tx_dst_rdy_low && link_state == PHI_LINK_L3) // RL13
    else $error("layers not closed after turn-off acknowledge");
  AST_TO_ACK: assert property ((!turnoff_request_low && !turnoff_ok_low) |=> turnoff_ack_send ##1 !turnoff_ack_send) // RL13
    else $error("acknowledge message not a single pulse");
  AST_L0_TRAINED: assert property ((link_state == PHI_LINK_L0 && $past(link_state) == PHI_LINK_DOWN) |-> $past(evt_linkup)) // RL3
    else $error("L0 entered without training");
  AST_L1_ENTRY: assert property ((link_state == PHI_LINK_L0 && non_d0 && !evt_linkdown && to_nxt != PHI_TO_OFF) |=> link_state == PHI_LINK_L1) // RL8
    else $error("link did not move to L1");
  AST_LINK_DROP: assert property ((evt_linkdown && link_r != PHI_LINK_L3 && to_nxt != PHI_TO_OFF) |=> link_state == PHI_LINK_DOWN) // RL2
    else $error("link did not go down");
  AST_TX_OPEN_D0: assert property ((!non_d0 && !off_r) |-> !tx_dst_rdy_low) // RL5
    else $error("transmit stalled in D0");
  AST_TO_QUIET: assert property ((to_r == PHI_TO_IDLE) |-> turnoff_request_low) // RL10
    else $error("turn-off request without message");
  AST_WAKE_ONCE: assert property (pme_msg_send |=> !pme_msg_send) // RL9
    else $error("PME message longer than one cycle");
  AST_TO_FINAL: assert property (layers_disabled |=> layers_disabled && turnoff_request_low) // RL13
    else $error("closed state left before reset");
  AST_IRQ_CLOSED: assert property (layers_disabled |=> intr_rdy_low) // RL13
    else $error("interrupt accepted after close");

endmodule : phi_pm_irq
`default_nettype wire

// *** sim/phi_user_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module phi_user_model #(
  parameter int OK_WAIT = 5
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic irq_go,
  input wire logic irq_assert,
  input wire logic [7:0] irq_vec,
  input wire logic intr_rdy_low,
  input wire logic turnoff_request_low,
  output logic intr_req_low,
  output logic intr_assert_low,
  output logic [7:0] intr_di,
  output logic turnoff_ok_low
);
  int wait_cnt;

  // The request stays low through the accept cycle and is dropped at the edge that sees it.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      intr_req_low <= 1'b1;
      intr_assert_low <= 1'b1;
      intr_di <= 8'h00;
    end else if (irq_go && intr_req_low) begin
      intr_req_low <= 1'b0;
      intr_assert_low <= ~irq_assert;
      intr_di <= irq_vec;
    end else if (!intr_req_low && !intr_rdy_low) begin
      intr_req_low <= 1'b1;
    end
  end

  // No packet is ever open here, so the only delay is a settling time before committing.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      turnoff_ok_low <= 1'b1;
      wait_cnt <= 0;
    end else if (!turnoff_request_low && turnoff_ok_low) begin
      if (wait_cnt == OK_WAIT) begin
        turnoff_ok_low <= 1'b0;
      end else begin
        wait_cnt <= wait_cnt + 1;
      end
    end
  end
endmodule : phi_user_model
`default_nettype wire

// *** sim/pm_handshake_and_irq_request_test.sv ***
`timescale 1ns/1ps
`default_nettype none
module pm_handshake_and_irq_request_test
  import phi_pkg::*;
;
  logic clk, reset_n, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [1:0] power_state, link_state;
  logic [2:0] mmenable;
  logic pme_enable, tx_src_rdy_low, tx_sof_low, tx_eof_low, tx_dst_rdy_low, wake_request_low;
  logic pme_msg_send, turnoff_request_low, turnoff_ok_low, turnoff_ack_send, layers_disabled;
  logic intr_req_low, intr_assert_low, intr_rdy_low, msi_enable, msix_enable;
  logic intx_msg_send, intx_msg_assert, msi_msg_send, irq_go, irq_assert, err;
  logic [7:0] intr_di, msi_msg_data, irq_vec;
  int n_errors = 0;
  int compares = 0;
  int cyc = 0;

  phi_pm_irq i_dut (.clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .power_state(power_state), .pme_enable(pme_enable),
    .link_state(link_state), .tx_src_rdy_low(tx_src_rdy_low), .tx_sof_low(tx_sof_low),
    .tx_eof_low(tx_eof_low), .tx_dst_rdy_low(tx_dst_rdy_low),
    .wake_request_low(wake_request_low), .pme_msg_send(pme_msg_send),
    .turnoff_request_low(turnoff_request_low), .turnoff_ok_low(turnoff_ok_low),
    .turnoff_ack_send(turnoff_ack_send), .layers_disabled(layers_disabled),
    .intr_req_low(intr_req_low), .intr_assert_low(intr_assert_low), .intr_di(intr_di),
    .intr_rdy_low(intr_rdy_low), .msi_enable(msi_enable), .msix_enable(msix_enable),
    .mmenable(mmenable), .intx_msg_send(intx_msg_send), .intx_msg_assert(intx_msg_assert),
    .msi_msg_send(msi_msg_send), .msi_msg_data(msi_msg_data));

  phi_user_model u_user (.clk(clk), .reset_n(reset_n), .irq_go(irq_go),
    .irq_assert(irq_assert), .irq_vec(irq_vec), .intr_rdy_low(intr_rdy_low),
    .turnoff_request_low(turnoff_request_low), .intr_req_low(intr_req_low),
    .intr_assert_low(intr_assert_low), .intr_di(intr_di), .turnoff_ok_low(turnoff_ok_low));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic wrap_up();
    $display("Checks %0d, mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : wrap_up

  // The wait on pready is bounded so a stuck slave shows up as a mismatch, not a hang.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    chk(n < 50, 1, "apb answer");
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic ctrl(input logic [31:0] v);
    apb(1'b1, PHI_OFF_CTRL, v);
    @(negedge clk);
  endtask : ctrl

  task automatic t_regs();
    apb(1'b0, PHI_OFF_CTRL, 32'h0);
    chk(rd, 32'h0, "ctrl reset");
    chk(err, 0, "ctrl err");
    apb(1'b0, 12'h010, 32'h0);
    chk(err, 1, "unmapped err");
    chk(rd, 32'h0, "unmapped data");
    $display("test regs done");
  endtask : t_regs

  task automatic t_link();
    chk(link_state, PHI_LINK_DOWN, "untrained");
    apb(1'b1, PHI_OFF_EVENT, 32'h1 << PHI_EVT_LINKUP_BIT);
    @(negedge clk);
    chk(link_state, PHI_LINK_L0, "trained");
    ctrl(32'h3);
    @(negedge clk);
    chk(link_state, PHI_LINK_L1, "enter L1");
    ctrl(32'h0);
    @(negedge clk);
    chk(link_state, PHI_LINK_L0, "back to L0");
    apb(1'b1, PHI_OFF_EVENT, 32'h1 << PHI_EVT_LINKDOWN_BIT);
    @(negedge clk);
    chk(link_state, PHI_LINK_DOWN, "link down");
    apb(1'b1, PHI_OFF_EVENT, 32'h1 << PHI_EVT_LINKUP_BIT);
    $display("test link done");
  endtask : t_link

  task automatic t_power();
    for (int p = 0; p < 4; p++) begin
      ctrl(p);
      chk(power_state, p, "power state");
      chk(tx_dst_rdy_low, p != 0, "tx stall");
    end
    ctrl(32'h0);
    @(posedge clk);
    tx_src_rdy_low <= 1'b0;
    tx_sof_low <= 1'b0;
    @(posedge clk);
    tx_src_rdy_low <= 1'b1;
    tx_sof_low <= 1'b1;
    ctrl(32'h3);
    chk(tx_dst_rdy_low, 0, "open packet ready");
    @(posedge clk);
    tx_src_rdy_low <= 1'b0;
    tx_eof_low <= 1'b0;
    @(posedge clk);
    tx_src_rdy_low <= 1'b1;
    tx_eof_low <= 1'b1;
    @(negedge clk);
    chk(tx_dst_rdy_low, 1, "stall after eof");
    $display("test power done");
  endtask : t_power

  task automatic wake(input logic exp);
    @(posedge clk);
    wake_request_low <= 1'b0;
    @(posedge clk);
    wake_request_low <= 1'b1;
    @(negedge clk);
    chk(pme_msg_send, exp, "wake pulse");
    @(negedge clk);
    chk(pme_msg_send, 0, "wake pulse end");
  endtask : wake

  task automatic t_wake();
    ctrl(32'h3);
    wake(1'b0);
    ctrl(32'h3 | (32'h1 << PHI_CTRL_PME_BIT));
    chk(pme_enable, 1, "pme mirror");
    wake(1'b1);
    apb(1'b0, PHI_OFF_STATUS, 32'h0);
    chk(rd[PHI_STS_WAKE_BIT], 1, "wake status");
    apb(1'b1, PHI_OFF_STATUS, 32'h1 << PHI_STS_WAKE_BIT);
    apb(1'b0, PHI_OFF_STATUS, 32'h0);
    chk(rd[PHI_STS_WAKE_BIT], 0, "wake status cleared");
    ctrl(32'h0 | (32'h1 << PHI_CTRL_PME_BIT));
    wake(1'b0);
    $display("test wake done");
  endtask : t_wake

  task automatic irq(input logic as, input logic [7:0] v, input logic ei, input logic em,
                     input logic [7:0] ed);
    int n;
    n = 0;
    @(posedge clk);
    irq_go <= 1'b1;
    irq_assert <= as;
    irq_vec <= v;
    @(posedge clk);
    irq_go <= 1'b0;
    do begin
      @(negedge clk);
      n++;
    end while (intr_rdy_low !== 1'b0 && n < 20);
    chk(n < 20, 1, "irq accepted");
    chk(intx_msg_send, ei, "intx sent");
    chk(msi_msg_send, em, "msi sent");
    if (em) begin
      chk(msi_msg_data, ed, "msi data");
    end
    if (ei) begin
      chk(intx_msg_assert, as, "intx level");
    end
    @(negedge clk);
    chk(intr_rdy_low, 1, "rdy one cycle");
  endtask : irq

  task automatic t_irq();
    logic m;
    for (int i = 0; i < 4; i++) begin
      m = i[1];
      ctrl((32'(m) << PHI_CTRL_MSI_BIT) | (32'(i[0]) << PHI_CTRL_MSIX_BIT));
      chk(msi_enable, m, "msi mirror");
      chk(msix_enable, i[0], "msix mirror");
      irq(~i[0], 8'h00, ~m, m, 8'h00);
    end
    ctrl(32'h1 << PHI_CTRL_INTXDIS_BIT);
    irq(1'b1, 8'h00, 1'b0, 1'b0, 8'h00);
    ctrl(32'h0);
    irq(1'b1, 8'h01, 1'b0, 1'b0, 8'h00);
    ctrl((32'h1 << PHI_CTRL_MSI_BIT) | (32'h2 << PHI_CTRL_MMEN_LSB));
    chk(mmenable, 3'h2, "mm enable");
    irq(1'b1, 8'hFF, 1'b0, 1'b1, 8'h03);
    apb(1'b0, PHI_OFF_STATUS, 32'h0);
    chk(rd, (32'h3 << PHI_STS_BLK_BIT) | 32'(PHI_LINK_L0), "irq status");
    $display("test irq done");
  endtask : t_irq

  task automatic t_turnoff();
    int n;
    n = 0;
    apb(1'b1, PHI_OFF_EVENT, 32'h1 << PHI_EVT_TURNOFF_BIT);
    repeat (4) begin
      @(negedge clk);
      chk(turnoff_request_low, 0, "turnoff held");
    end
    do begin
      @(negedge clk);
      n++;
    end while (turnoff_ack_send !== 1'b1 && n < 20);
    chk(turnoff_request_low, 1, "turnoff released");
    chk(turnoff_ack_send, 1, "ack sent");
    @(negedge clk);
    chk(layers_disabled, 1, "closed");
    chk(link_state, PHI_LINK_L3, "link off");
    chk(tx_dst_rdy_low, 1, "tx closed");
    @(posedge clk);
    irq_go <= 1'b1;
    @(posedge clk);
    irq_go <= 1'b0;
    n = 0;
    repeat (8) begin
      @(negedge clk);
      n += (intr_rdy_low !== 1'b1);
    end
    chk(n, 0, "irq refused when closed");
    apb(1'b0, PHI_OFF_MSGCNT, 32'h0);
    chk(rd, 32'h0002_0005, "message counts");
    $display("test turnoff done");
  endtask : t_turnoff

  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      wrap_up();
    end
  end

  initial begin
    reset_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    tx_src_rdy_low = 1'b1;
    tx_sof_low = 1'b1;
    tx_eof_low = 1'b1;
    wake_request_low = 1'b1;
    irq_go = 1'b0;
    irq_assert = 1'b1;
    irq_vec = 8'h00;
    repeat (12) @(posedge clk);
    @(negedge clk);
    chk(turnoff_request_low & intr_rdy_low, 1, "reset levels");
    chk(power_state, PHI_PWR_D0, "reset power");
    @(posedge clk);
    reset_n <= 1'b1;
    t_regs();
    t_link();
    t_power();
    t_wake();
    t_irq();
    t_turnoff();
    wrap_up();
  end
endmodule : pm_handshake_and_irq_request_test
`default_nettype wire
